/* include/dpll_cfg_pkg.sv */
// Purpose: Shared constants for the feedback divider and loop filter configuration block
// Assumes: 32-bit APB data, one register per aligned word, byte address = 4 * index
// Notes: Register indices are kept as printed; the bus decodes paddr[11:2] against them
package dpll_cfg_pkg;

	// Address shape
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	localparam int DATA_W = 32;

	// Register indices
	localparam logic [IDX_W-1:0] IDX_FB_DIV_LOW = 10'h104;
	localparam logic [IDX_W-1:0] IDX_FB_DIV_HIGH = 10'h105;
	localparam logic [IDX_W-1:0] IDX_FB_DIV_CTRL = 10'h106;
	localparam logic [IDX_W-1:0] IDX_FILTER_RATE = 10'h107;
	localparam logic [IDX_W-1:0] IDX_COEF_A_LOW = 10'h108;
	localparam logic [IDX_W-1:0] IDX_COEF_A_HIGH = 10'h109;
	localparam logic [IDX_W-1:0] IDX_COEF_A_UP = 10'h10a;
	localparam logic [IDX_W-1:0] IDX_COEF_A_DOWN = 10'h10b;
	localparam logic [IDX_W-1:0] IDX_COEF_B_LOW = 10'h10c;
	localparam logic [IDX_W-1:0] IDX_COEF_B_HIGH = 10'h10d;
	localparam logic [IDX_W-1:0] IDX_COEF_B_DOWN = 10'h10e;
	localparam logic [IDX_W-1:0] IDX_COEF_C_LOW = 10'h10f;
	localparam logic [IDX_W-1:0] IDX_COEF_C_DOWN = 10'h111;
	localparam logic [IDX_W-1:0] IDX_COMMIT = 10'h180;
	localparam logic [IDX_W-1:0] IDX_STATUS = 10'h181;

	// Field widths
	localparam int DIV_W = 16;
	localparam int BYTE_W = 8;
	localparam int MANT_W = 12;
	localparam int MANT_HI_W = 4;
	localparam int RATE_W = 5;
	localparam int UP_W = 5;
	localparam int DOWN_W = 3;
	localparam int TICK_CNT_W = 32;
	localparam int COEF_A_W = 43;

	// Field positions
	localparam int CTRL_PRESCALE_BIT = 0;
	localparam int CTRL_INVERT_BIT = 7;
	localparam int COMMIT_BIT = 0;
	localparam int STATUS_PENDING_BIT = 0;
	localparam int STATUS_PHASE_BIT = 1;
	localparam int STATUS_COUNT_LSB = 16;

	// Reset values
	localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;
	localparam logic [DIV_W-1:0] RESET_DIV = 16'h0000;
	localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

endpackage : dpll_cfg_pkg

/* rtl/dpll_feedback_and_loop_config.sv */
// Purpose: APB register bank for the feedback divider and loop filter coefficients
// Assumes: pclk is the system clock; feedback_clock_input is synchronous to pclk
// Notes: Software writes shadows; a commit write moves all of them into use at once
//
// Summary of operation
// - Feedback ratio is programmed value plus one
// - Low byte lower address, high byte next
// - Zero divider passes every feedback edge
// - Control bit 0 adds divide-by-two prescaler
// - Control bit 7 divides on falling edges
// - Filter tick every two-to-exponent system clocks
// - Filter rate base is the system clock
// - First coefficient 12-bit mantissa over two registers
// - First coefficient shifted up by 5-bit exponent
// - First coefficient shifted down by 3-bit exponent
// - Second coefficient 12-bit mantissa over two registers
// - Second coefficient shifted down by 3-bit exponent
// - Third coefficient low mantissa byte own register
// - Third coefficient 3-bit down exponent passed out unshifted on coef_c_down
module dpll_feedback_and_loop_config (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dpll_cfg_pkg::ADDR_W-1:0] paddr,
	input wire logic [dpll_cfg_pkg::DATA_W-1:0] pwdata,
	output logic [dpll_cfg_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic feedback_clock_input,
	output logic feedback_divided,
	output logic filter_tick,
	output logic [dpll_cfg_pkg::COEF_A_W-1:0] coef_a_value,
	output logic [dpll_cfg_pkg::MANT_W-1:0] coef_b_value,
	output logic [dpll_cfg_pkg::BYTE_W-1:0] coef_c_low_value,
	output logic [dpll_cfg_pkg::DOWN_W-1:0] coef_c_down
);
	import dpll_cfg_pkg::*;

	// Shadow copies written by software
	logic [DIV_W-1:0] sh_div;
	logic sh_prescale;
	logic sh_invert;
	logic [RATE_W-1:0] sh_rate;
	logic [MANT_W-1:0] sh_a_mant;
	logic [UP_W-1:0] sh_a_up;
	logic [DOWN_W-1:0] sh_a_down;
	logic [MANT_W-1:0] sh_b_mant;
	logic [DOWN_W-1:0] sh_b_down;
	logic [BYTE_W-1:0] sh_c_low;
	logic [DOWN_W-1:0] sh_c_down;

	// Active copies seen by the datapath
	logic [DIV_W-1:0] act_div;
	logic act_prescale;
	logic act_invert;
	logic [RATE_W-1:0] act_rate;
	logic [MANT_W-1:0] act_a_mant;
	logic [UP_W-1:0] act_a_up;
	logic [DOWN_W-1:0] act_a_down;
	logic [MANT_W-1:0] act_b_mant;
	logic [DOWN_W-1:0] act_b_down;
	logic [BYTE_W-1:0] act_c_low;
	logic [DOWN_W-1:0] act_c_down;

	logic pending;
	logic fb_q;
	logic pre_phase;
	logic [DIV_W-1:0] div_count;
	logic [TICK_CNT_W-1:0] tick_count;

	logic [IDX_W-1:0] idx;
	logic addr_ok;
	logic setup_rd;
	logic wr_access;
	logic commit;
	logic fb_rise;
	logic fb_fall;
	logic fb_edge;
	logic pre_edge;
	logic [TICK_CNT_W-1:0] rate_mask;

	// Known register words only; low address bits must be zero
	function automatic logic is_mapped(input logic [IDX_W-1:0] i);
		unique case (i)
			IDX_FB_DIV_LOW, IDX_FB_DIV_HIGH, IDX_FB_DIV_CTRL, IDX_FILTER_RATE,
			IDX_COEF_A_LOW, IDX_COEF_A_HIGH, IDX_COEF_A_UP, IDX_COEF_A_DOWN,
			IDX_COEF_B_LOW, IDX_COEF_B_HIGH, IDX_COEF_B_DOWN, IDX_COEF_C_LOW,
			IDX_COEF_C_DOWN, IDX_COMMIT, IDX_STATUS: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// Power-of-two mask, all ones below the exponent
	function automatic logic [TICK_CNT_W-1:0] low_mask(input logic [RATE_W-1:0] e);
		low_mask = (TICK_CNT_W'(1) << e) - TICK_CNT_W'(1);
	endfunction : low_mask

	// Bus decode
	assign idx = paddr[ADDR_W-1:2];
	assign addr_ok = (paddr[1:0] == 2'b00) && is_mapped(idx);
	assign setup_rd = psel && !penable && !pwrite;
	assign wr_access = psel && penable && pwrite && addr_ok;
	assign commit = wr_access && (idx == IDX_COMMIT) && pwdata[COMMIT_BIT];

	// Zero-wait slave; error only on an unmapped access phase
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	// Shadow register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_div <= RESET_DIV;
			sh_prescale <= 1'b0;
			sh_invert <= 1'b0;
			sh_rate <= '0;
			sh_a_mant <= '0;
			sh_a_up <= '0;
			sh_a_down <= '0;
			sh_b_mant <= '0;
			sh_b_down <= '0;
			sh_c_low <= RESET_BYTE;
			sh_c_down <= '0;
		end else if (wr_access) begin
			unique case (idx)
				IDX_FB_DIV_LOW: sh_div[BYTE_W-1:0] <= pwdata[BYTE_W-1:0];
				IDX_FB_DIV_HIGH: sh_div[DIV_W-1:BYTE_W] <= pwdata[BYTE_W-1:0];
				IDX_FB_DIV_CTRL: begin
					// Bits 6..1 are dropped, so they can never steer the divider
					sh_prescale <= pwdata[CTRL_PRESCALE_BIT];
					sh_invert <= pwdata[CTRL_INVERT_BIT];
				end
				IDX_FILTER_RATE: sh_rate <= pwdata[RATE_W-1:0];
				IDX_COEF_A_LOW: sh_a_mant[BYTE_W-1:0] <= pwdata[BYTE_W-1:0];
				IDX_COEF_A_HIGH: sh_a_mant[MANT_W-1:BYTE_W] <= pwdata[MANT_HI_W-1:0];
				IDX_COEF_A_UP: sh_a_up <= pwdata[UP_W-1:0];
				IDX_COEF_A_DOWN: sh_a_down <= pwdata[DOWN_W-1:0];
				IDX_COEF_B_LOW: sh_b_mant[BYTE_W-1:0] <= pwdata[BYTE_W-1:0];
				IDX_COEF_B_HIGH: sh_b_mant[MANT_W-1:BYTE_W] <= pwdata[MANT_HI_W-1:0];
				IDX_COEF_B_DOWN: sh_b_down <= pwdata[DOWN_W-1:0];
				IDX_COEF_C_LOW: sh_c_low <= pwdata[BYTE_W-1:0];
				IDX_COEF_C_DOWN: sh_c_down <= pwdata[DOWN_W-1:0];
				default: ;
			endcase
		end
	end

	// All fields move to the datapath in one edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_div <= RESET_DIV;
			act_prescale <= 1'b0;
			act_invert <= 1'b0;
			act_rate <= '0;
			act_a_mant <= '0;
			act_a_up <= '0;
			act_a_down <= '0;
			act_b_mant <= '0;
			act_b_down <= '0;
			act_c_low <= RESET_BYTE;
			act_c_down <= '0;
		end else if (commit) begin
			act_div <= sh_div;
			act_prescale <= sh_prescale;
			act_invert <= sh_invert;
			act_rate <= sh_rate;
			act_a_mant <= sh_a_mant;
			act_a_up <= sh_a_up;
			act_a_down <= sh_a_down;
			act_b_mant <= sh_b_mant;
			act_b_down <= sh_b_down;
			act_c_low <= sh_c_low;
			act_c_down <= sh_c_down;
		end
	end

	// Pending flag: set by any shadow write, cleared by commit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= 1'b0;
		end else if (wr_access && idx != IDX_COMMIT && idx != IDX_STATUS) begin
			pending <= 1'b1;
		end else if (commit) begin
			pending <= 1'b0;
		end
	end

	// Read data captured in the setup cycle, ready for the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= RESET_WORD;
		end else if (setup_rd) begin
			prdata <= RESET_WORD;
			unique case (idx)
				IDX_FB_DIV_LOW: prdata[BYTE_W-1:0] <= sh_div[BYTE_W-1:0];
				IDX_FB_DIV_HIGH: prdata[BYTE_W-1:0] <= sh_div[DIV_W-1:BYTE_W];
				IDX_FB_DIV_CTRL: begin
					prdata[CTRL_PRESCALE_BIT] <= sh_prescale;
					prdata[CTRL_INVERT_BIT] <= sh_invert;
				end
				IDX_FILTER_RATE: prdata[RATE_W-1:0] <= sh_rate;
				IDX_COEF_A_LOW: prdata[BYTE_W-1:0] <= sh_a_mant[BYTE_W-1:0];
				IDX_COEF_A_HIGH: prdata[MANT_HI_W-1:0] <= sh_a_mant[MANT_W-1:BYTE_W];
				IDX_COEF_A_UP: prdata[UP_W-1:0] <= sh_a_up;
				IDX_COEF_A_DOWN: prdata[DOWN_W-1:0] <= sh_a_down;
				IDX_COEF_B_LOW: prdata[BYTE_W-1:0] <= sh_b_mant[BYTE_W-1:0];
				IDX_COEF_B_HIGH: prdata[MANT_HI_W-1:0] <= sh_b_mant[MANT_W-1:BYTE_W];
				IDX_COEF_B_DOWN: prdata[DOWN_W-1:0] <= sh_b_down;
				IDX_COEF_C_LOW: prdata[BYTE_W-1:0] <= sh_c_low;
				IDX_COEF_C_DOWN: prdata[DOWN_W-1:0] <= sh_c_down;
				IDX_STATUS: begin
					prdata[STATUS_PENDING_BIT] <= pending;
					prdata[STATUS_PHASE_BIT] <= pre_phase;
					prdata[STATUS_COUNT_LSB +: DIV_W] <= div_count;
				end
				default: ;
			endcase
		end
	end

	// Feedback edge selection; a single sample delay gives edge detect
	assign fb_rise = feedback_clock_input && !fb_q;
	assign fb_fall = !feedback_clock_input && fb_q;
	assign fb_edge = act_invert ? fb_fall : fb_rise;
	// Prescaler passes every second selected edge
	assign pre_edge = fb_edge && (!act_prescale || pre_phase);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb_q <= 1'b0;
		end else begin
			fb_q <= feedback_clock_input;
		end
	end

	// Prescale phase toggles on each selected edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_phase <= 1'b0;
		end else if (!act_prescale) begin
			pre_phase <= 1'b0;
		end else if (fb_edge) begin
			pre_phase <= !pre_phase;
		end
	end

	// Divide by value plus one; >= wraps cleanly after a smaller value is committed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_count <= RESET_DIV;
			feedback_divided <= 1'b0;
		end else begin
			feedback_divided <= 1'b0;
			if (pre_edge) begin
				if (div_count >= act_div) begin
					div_count <= RESET_DIV;
					feedback_divided <= 1'b1;
				end else begin
					div_count <= div_count + DIV_W'(1);
				end
			end
		end
	end

	// Loop filter tick from the system clock itself
	assign rate_mask = low_mask(act_rate);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_count <= '0;
			filter_tick <= 1'b0;
		end else begin
			tick_count <= tick_count + TICK_CNT_W'(1);
			filter_tick <= ((tick_count & rate_mask) == rate_mask);
		end
	end

	// Coefficient scaling; the up shift cannot overflow the wide result
	assign coef_a_value = (COEF_A_W'(act_a_mant) << act_a_up) >> act_a_down;
	assign coef_b_value = act_b_mant >> act_b_down;
	assign coef_c_low_value = act_c_low;
	assign coef_c_down = act_c_down;

	// Checks
	sequence s_commit_write;
		psel && penable && pwrite && addr_ok && idx == IDX_COMMIT && pwdata[COMMIT_BIT];
	endsequence

	sequence s_zero_div_edge;
		act_div == RESET_DIV && pre_edge;
	endsequence

	property p_ratio_one;
		@(posedge pclk) disable iff (!presetn) s_zero_div_edge |=> feedback_divided;
	endproperty
	a_ratio_one: assert property (p_ratio_one) else $error("zero divider dropped an edge");

	property p_count_wraps;
		@(posedge pclk) disable iff (!presetn) feedback_divided |-> div_count == RESET_DIV;
	endproperty
	a_count_wraps: assert property (p_count_wraps) else $error("divider output without wrap");

	property p_commit_moves;
		@(posedge pclk) disable iff (!presetn) s_commit_write |=> act_div == $past(sh_div) && !pending;
	endproperty
	a_commit_moves: assert property (p_commit_moves) else $error("commit did not load divider");

	property p_no_mix;
		@(posedge pclk) disable iff (!presetn) !commit |=> $stable(act_div) && $stable(act_a_mant);
	endproperty
	a_no_mix: assert property (p_no_mix) else $error("active field changed without commit");

	property p_prescale_skip;
		@(posedge pclk) disable iff (!presetn) act_prescale && fb_edge && !pre_phase |-> !pre_edge;
	endproperty
	a_prescale_skip: assert property (p_prescale_skip) else $error("prescaler passed odd edge");

	property p_falling;
		@(posedge pclk) disable iff (!presetn) act_invert && $fell(feedback_clock_input) |-> fb_edge;
	endproperty
	a_falling: assert property (p_falling) else $error("inverted edge not seen");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
			psel && penable && !pwrite && idx == IDX_FB_DIV_CTRL |-> prdata[6:1] == 6'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bits read nonzero");

	property p_tick_every;
		@(posedge pclk) disable iff (!presetn) (act_rate == 5'h00) [*3] |-> filter_tick;
	endproperty
	a_tick_every: assert property (p_tick_every) else $error("exponent zero missed a tick");

	property p_tick_half;
		@(posedge pclk) disable iff (!presetn) (act_rate == 5'h01) [*3] ##0 filter_tick |=> !filter_tick;
	endproperty
	a_tick_half: assert property (p_tick_half) else $error("exponent one ticked twice");

	property p_unmapped;
		@(posedge pclk) disable iff (!presetn) psel && penable && !addr_ok |-> pslverr && pready;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");

endmodule : dpll_feedback_and_loop_config

/* verification/testbench.sv */
// Purpose: Self-checking bench for the feedback divider and loop filter register bank
// Assumes: APB with pready tied high, shadows reach the datapath only on a commit write
// Notes: Register reads are checked by a watcher process fed from a queue of notes
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import dpll_cfg_pkg::*;

	logic pclk, presetn, psel, penable, pwrite, fb_in;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic pready, pslverr, feedback_divided, filter_tick;
	logic [COEF_A_W-1:0] coef_a_value;
	logic [MANT_W-1:0] coef_b_value;
	logic [BYTE_W-1:0] coef_c_low_value;
	logic [DOWN_W-1:0] coef_c_down;
	int fail_count = 0;
	int total_checks = 0;
	int pulse_count = 0;
	int tick_count = 0;
	logic [DATA_W:0] read_notes[$];
	localparam logic [IDX_W-1:0] REG_IDX[13] = '{IDX_FB_DIV_LOW, IDX_FB_DIV_HIGH, IDX_FB_DIV_CTRL,
		IDX_FILTER_RATE, IDX_COEF_A_LOW, IDX_COEF_A_HIGH, IDX_COEF_A_UP, IDX_COEF_A_DOWN,
		IDX_COEF_B_LOW, IDX_COEF_B_HIGH, IDX_COEF_B_DOWN, IDX_COEF_C_LOW, IDX_COEF_C_DOWN};
	localparam logic [7:0] REG_MASK[13] = '{8'hff, 8'hff, 8'h81, 8'h1f, 8'hff, 8'h0f, 8'h1f, 8'h07,
		8'hff, 8'h0f, 8'h07, 8'hff, 8'h07};
	localparam int RATES[4] = '{0, 1, 3, 5};

	dpll_feedback_and_loop_config u_dpll_feedback_and_loop_config (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.feedback_clock_input(fb_in),
		.feedback_divided(feedback_divided),
		.filter_tick(filter_tick),
		.coef_a_value(coef_a_value),
		.coef_b_value(coef_b_value),
		.coef_c_low_value(coef_c_low_value),
		.coef_c_down(coef_c_down)
	);

	// Free-running 200 MHz system clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			tally_and_finish();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Note the expected {pslverr, prdata} before the read goes out
	task automatic rd(input logic [IDX_W-1:0] idx, input logic [DATA_W:0] exp);
		read_notes.push_back(exp);
		apb(1'b0, idx, '0);
	endtask : rd

	// Watcher: read data taken at the edge that completes the access
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			if (read_notes.size() == 0) begin
				check(64'h1, 64'h0);
			end else begin
				check({pslverr, prdata}, read_notes.pop_front());
			end
		end
		if (feedback_divided === 1'b1) pulse_count++;
		if (filter_tick === 1'b1) tick_count++;
	end

	// Fresh reset so the divider count starts from zero, then count output pulses
	task automatic fb_case(input logic [DIV_W-1:0] dv, input logic [7:0] ctrl, input int toggles, input int exp);
		int base;
		presetn <= 1'b0;
		fb_in <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, IDX_FB_DIV_LOW, {24'h0, dv[7:0]});
		apb(1'b1, IDX_FB_DIV_HIGH, {24'h0, dv[15:8]});
		apb(1'b1, IDX_FB_DIV_CTRL, {24'h0, ctrl});
		apb(1'b1, IDX_COMMIT, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		// Snapshot instead of clearing, so only the watcher writes the counter
		@(negedge pclk) base = pulse_count;
		repeat (toggles) begin
			@(posedge pclk);
			fb_in <= ~fb_in;
			@(posedge pclk);
		end
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		check(pulse_count - base, exp);
		$display("test divider %h ctrl %h done", dv, ctrl);
	endtask : fb_case

	initial begin
		logic [DATA_W-1:0] wv[13];
		logic [MANT_W-1:0] ma, mb;
		logic [7:0] mc;
		logic [4:0] ua;
		logic [2:0] da, db, dc;
		logic [COEF_A_W-1:0] ea;
		logic [MANT_W-1:0] eb;
		logic [10:0] ecc;
		int seed;
		int base;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		fb_in = 1'b0;
		presetn = 1'b0;
		ea = '0;
		eb = '0;
		ecc = '0;
		seed = $urandom(23349);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, then random words read back through the field masks
		foreach (REG_IDX[i]) rd(REG_IDX[i], {1'b0, RESET_WORD});
		foreach (REG_IDX[i]) begin
			wv[i] = $urandom;
			apb(1'b1, REG_IDX[i], wv[i]);
		end
		foreach (REG_IDX[i]) rd(REG_IDX[i], {1'b0, 24'h0, wv[i][7:0] & REG_MASK[i]});
		rd(10'h1ff, {1'b1, 32'h0});
		$display("test registers done");
		// A and B shadows must not leak before commit; all fields switch together
		repeat (3) begin
			ma = $urandom;
			mb = $urandom;
			mc = $urandom;
			ua = $urandom;
			da = $urandom;
			db = $urandom;
			dc = $urandom;
			apb(1'b1, IDX_COEF_A_LOW, {24'h0, ma[7:0]});
			apb(1'b1, IDX_COEF_A_HIGH, {28'h0, ma[11:8]});
			apb(1'b1, IDX_COEF_A_UP, {27'h0, ua});
			apb(1'b1, IDX_COEF_A_DOWN, {29'h0, da});
			apb(1'b1, IDX_COEF_B_LOW, {24'h0, mb[7:0]});
			apb(1'b1, IDX_COEF_B_HIGH, {28'h0, mb[11:8]});
			apb(1'b1, IDX_COEF_B_DOWN, {29'h0, db});
			apb(1'b1, IDX_COEF_C_LOW, {24'h0, mc});
			apb(1'b1, IDX_COEF_C_DOWN, {29'h0, dc});
			@(negedge pclk);
			check({coef_b_value, coef_a_value}, {eb, ea});
			apb(1'b1, IDX_COMMIT, 32'h0000_0001);
			@(negedge pclk);
			ea = ({31'h0, ma} << ua) >> da;
			eb = mb >> db;
			ecc = {dc, mc};
			check(coef_a_value, ea);
			check(coef_b_value, eb);
			check({coef_c_down, coef_c_low_value}, ecc);
		end
		$display("test coefficients done");
		// Tick count over a 64-cycle window is 64 / 2^exponent
		foreach (RATES[i]) begin
			apb(1'b1, IDX_FILTER_RATE, RATES[i]);
			apb(1'b1, IDX_COMMIT, 32'h0000_0001);
			repeat (4) @(posedge pclk);
			@(negedge pclk) base = tick_count;
			repeat (64) @(negedge pclk);
			check(tick_count - base, 64 >> RATES[i]);
		end
		$display("test filter rate done");
		// Odd toggle count: 24 rising edges, 23 falling edges
		fb_case(16'h0000, 8'h00, 47, 24);
		fb_case(16'h0000, 8'h80, 47, 23);
		fb_case(16'h0002, 8'h00, 48, 8);
		fb_case(16'h0100, 8'h00, 1028, 2);
		fb_case(16'h0002, 8'h01, 48, 4);
		fb_case(16'h0002, 8'h7e, 48, 8);
		tally_and_finish();
	end
endmodule : testbench
